/* File: logic/trim_map.svh */
// Purpose: register offsets, field positions and reset values of the I-channel trim bank
// Assumes: APB byte addresses are four times the register index
// Notes:   definitions only
`ifndef TRIM_MAP_SVH
`define TRIM_MAP_SVH
`define OFS_TRIM_INDEX     4'h2
`define FSR_TRIM_INDEX     4'h3
`define OFS_TRIM_RESET     16'h0000
`define FSR_TRIM_RESET     16'h4000
`define OFS_SIGN_BIT       12
`define OFS_MAG_MSB        11
`define FSR_MAG_MSB        14
`define OFS_WRITE_MASK     16'h1fff
`define FSR_WRITE_MASK     16'h7fff
`define FSR_MIN_CODE       15'h4000
`endif

/* File: logic/trim_pkg.sv */
// Purpose: types shared by the trim bank modules
// Assumes: none
// Notes:   constants live in trim_map.svh
package trim_pkg;
  typedef logic [15:0] trim_word_t;
  typedef logic [11:0] ofs_mag_t;
  typedef logic [14:0] fsr_mag_t;
endpackage

/* File: logic/trim_reg_if.sv */
// Purpose: write port bundle between the bus slave and a trim word
// Assumes: single clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface trim_reg_if;
  import trim_pkg::*;
  logic       we;
  trim_word_t wdata;
  trim_word_t q;
  modport ctl (output we, output wdata, input q);
  modport reg_side (input we, input wdata, output q);
endinterface
`default_nettype wire

/* File: logic/trim_word.sv */
// Purpose: one 16-bit trim word with write mask and reset value
// Assumes: pclk domain, asynchronous active-low reset
// Notes:   masked bits always read as zero
`timescale 1ns/1ps
`default_nettype none
module trim_word #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK     = 16'hffff
) (
  input  wire logic pclk,
  input  wire logic presetn,
  trim_reg_if.reg_side port
);
  import trim_pkg::*;
  trim_word_t word_r;
  trim_word_t word_nxt;
  initial begin
    if ((RESET_VAL & ~WMASK) != 16'h0000) $error("reset value outside write mask");
  end
  // next value: store masked write data
  always_comb begin
    word_nxt = word_r;
    if (port.we) begin
      word_nxt = port.wdata & WMASK;
    end
  end
  // register the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= RESET_VAL;
    end else begin
      word_r <= word_nxt;
    end
  end
  assign port.q = word_r;
endmodule // trim_word
`default_nettype wire

/* File: logic/ichan_offset_fsr_regs.sv */
// Purpose: APB bank of I-channel offset and full-scale trims, with offset applied to samples
// Assumes: pclk 125 MHz; samples arrive on pclk
// Notes:   zero-wait-state APB slave; unmapped addresses read zero and raise pslverr
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "trim_map.svh"
// Operation
// - sign zero adds offset magnitude to output
// - sign one subtracts offset magnitude
// - twelve-bit unsigned magnitude, zero means none
// - offset scales linearly with magnitude code
// - fullscale field straight binary, default 16384
module ichan_offset_fsr_regs #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  output var  logic signed [SAMPLE_W-1:0] sample_out,
  output var  trim_pkg::fsr_mag_t  fullscale_magnitude_field,
  output var  logic                fullscale_code_low
);
  import trim_pkg::*;
  trim_reg_if ofs_if ();
  trim_reg_if fsr_if ();
  logic       hit_ofs;
  logic       hit_fsr;
  logic       wr_en;
  logic       offset_sign_bit;
  ofs_mag_t   offset_magnitude_field;
  logic signed [SAMPLE_W+1:0] sum;
  logic signed [SAMPLE_W-1:0] sample_nxt;
  logic signed [SAMPLE_W-1:0] sample_r;
  localparam logic signed [SAMPLE_W+1:0] SMAX = (SAMPLE_W+2)'(2**(SAMPLE_W-1)-1);
  localparam logic signed [SAMPLE_W+1:0] SMIN = -(SAMPLE_W+2)'(2**(SAMPLE_W-1));
  initial begin
    if (SAMPLE_W < 13) $error("sample width must hold the offset magnitude");
  end
  // address decode, word aligned
  assign hit_ofs = (paddr[7:2] == {2'b00, `OFS_TRIM_INDEX}) && (paddr[1:0] == 2'b00);
  assign hit_fsr = (paddr[7:2] == {2'b00, `FSR_TRIM_INDEX}) && (paddr[1:0] == 2'b00);
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_ofs && !hit_fsr;
  // write strobes
  assign ofs_if.we    = wr_en && hit_ofs;
  assign ofs_if.wdata = pwdata[15:0];
  assign fsr_if.we    = wr_en && hit_fsr;
  assign fsr_if.wdata = pwdata[15:0];
  trim_word #(.RESET_VAL(`OFS_TRIM_RESET), .WMASK(`OFS_WRITE_MASK)) u_ofs (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (ofs_if.reg_side)
  );
  trim_word #(.RESET_VAL(`FSR_TRIM_RESET), .WMASK(`FSR_WRITE_MASK)) u_fsr (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (fsr_if.reg_side)
  );
  // read mux, combinational during access
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && hit_ofs) begin
      prdata = {16'h0000, ofs_if.q};
    end else if (psel && hit_fsr) begin
      prdata = {16'h0000, fsr_if.q};
    end
  end
  // field extraction
  assign offset_sign_bit           = ofs_if.q[`OFS_SIGN_BIT];
  assign offset_magnitude_field    = ofs_if.q[`OFS_MAG_MSB:0];
  assign fullscale_magnitude_field = fsr_if.q[`FSR_MAG_MSB:0];
  assign fullscale_code_low        = fullscale_magnitude_field < `FSR_MIN_CODE;
  // apply linear offset, one sample lsb per code, saturating
  always_comb begin
    if (offset_sign_bit) begin
      sum = (SAMPLE_W+2)'(sample_in) - (SAMPLE_W+2)'({1'b0, offset_magnitude_field});
    end else begin
      sum = (SAMPLE_W+2)'(sample_in) + (SAMPLE_W+2)'({1'b0, offset_magnitude_field});
    end
    if (sum > SMAX) begin
      sample_nxt = SMAX[SAMPLE_W-1:0];
    end else if (sum < SMIN) begin
      sample_nxt = SMIN[SAMPLE_W-1:0];
    end else begin
      sample_nxt = sum[SAMPLE_W-1:0];
    end
  end
  // register corrected sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_r <= '0;
    end else begin
      sample_r <= sample_nxt;
    end
  end
  assign sample_out = sample_r;
endmodule // ichan_offset_fsr_regs
`default_nettype wire

/* File: tb/trim_monitor.sv */
// Purpose: checks on the trim bank ports
// Assumes: bound to the top module
// Notes: keeps its own copy of the offset word
`timescale 1ns/1ps
`default_nettype none
module trim_monitor #(parameter int SAMPLE_W = 16) (
  input wire logic pclk, presetn, psel, penable, pwrite, pslverr, fullscale_code_low,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic signed [SAMPLE_W-1:0] sample_in, sample_out,
  input wire trim_pkg::fsr_mag_t fullscale_magnitude_field
);
  logic [12:0] o_r;
  int e;
  wire acc = psel & penable;
  wire big = e > 2**(SAMPLE_W-1)-1 || e < -(2**(SAMPLE_W-1));
  // offset copy follows bus writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) o_r <= '0;
    else if (acc && pwrite && paddr == 8'h08) o_r <= pwdata[12:0];
  // unclamped trimmed sample
  always_comb e = o_r[12] ? int'(sample_in) - int'(o_r[11:0]) : int'(sample_in) + int'(o_r[11:0]);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sign_add: assert property (!o_r[12] && !big |=> sample_out == $past(e))
    else $error("offset add wrong");
  chk_sign_sub: assert property (o_r[12] && !big |=> sample_out == $past(e))
    else $error("offset subtract wrong");
  chk_zero_mag: assert property (o_r[11:0] == 0 |=> sample_out == $past(sample_in))
    else $error("zero offset changed sample");
  chk_ofs_read: assert property (acc && !pwrite && paddr == 8'h08 |-> prdata == {19'h0, o_r})
    else $error("offset readback wrong");
  chk_fsr_write: assert property (acc && pwrite && paddr == 8'h0c |=>
    fullscale_magnitude_field == $past(pwdata[14:0])) else $error("fullscale write lost");
  chk_fsr_low: assert property (fullscale_code_low == (fullscale_magnitude_field < 15'h4000))
    else $error("low code flag wrong");
  // main scenarios
  cover property (o_r[12] && o_r[11:0] != 0);
  cover property (big);
  cover property (acc && pslverr);
endmodule // trim_monitor
`default_nettype wire

/* File: tb/ichan_offset_fsr_regs_bench.sv */
// Purpose: random bench for the trim bank
// Assumes: 125 MHz pclk, seed 63
// Notes: expected samples from sat()
`timescale 1ns/1ps
`default_nettype none
module ichan_offset_fsr_regs_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, low;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic err;
  logic [15:0] sample_in = 0, sample_out, fc[3] = '{16'h3fff, 16'h4000, 16'h7fff};
  trim_pkg::fsr_mag_t fsr;
  int mismatches = 0, total_checks = 0;
  ichan_offset_fsr_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_in, .sample_out, .fullscale_magnitude_field(fsr),
    .fullscale_code_low(low));
  initial forever #4 pclk = ~pclk;
  task automatic check(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer, read data left in rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk) n++; while (pready !== 1 && n < 20);
    if (n >= 20) mismatches++;
    if (n >= 20) tally_and_finish;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] sat(int v);
    return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : 16'(v);
  endfunction
  initial begin
    logic [12:0] o;
    void'($urandom(63));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h08, 0); check(rd, 32'h0000);
    check(err, 0);
    apb(0, 8'h10, 0); check(rd, 0);
    check(err, 1);
    foreach (fc[i]) begin
      apb(1, 8'h0c, fc[i]); apb(0, 8'h0c, 0); check(rd, fc[i]);
      check(low, fc[i] < 16'h4000);
      check(fsr, fc[i][14:0]);
    end
    $display("fullscale test done");
    for (int i = 0; i < 40; i++) begin
      o = i == 0 ? 13'h0 : i == 1 ? 13'h0fff : i == 2 ? 13'h1fff : 13'($urandom);
      apb(1, 8'h08, o); apb(0, 8'h08, 0); check(rd, o);
      sample_in <= i % 4 == 1 ? 16'h7fff : i % 4 == 2 ? 16'h8000 : 16'($urandom);
      repeat (2) @(posedge pclk);
      check(sample_out, sat(o[12] ? int'(signed'(sample_in)) - o[11:0]
        : int'(signed'(sample_in)) + o[11:0]));
    end
    $display("offset test done");
    // mid-run reset restores both power-on values
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h08, 0); check(rd, 32'h0000);
    apb(0, 8'h0c, 0); check(rd, 32'h4000);
    $display("reset test done");
    tally_and_finish;
  end
endmodule // ichan_offset_fsr_regs_bench
bind ichan_offset_fsr_regs trim_monitor #(.SAMPLE_W(SAMPLE_W)) mon_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .pslverr, .fullscale_code_low, .paddr, .pwdata, .prdata, .sample_in,
  .sample_out, .fullscale_magnitude_field);
`default_nettype wire
